// >>> core/expander_regs.svh
// constants of the peripheral interrupt expander
`ifndef EXPANDER_REGS_SVH
`define EXPANDER_REGS_SVH

// ==========================================
// sizes
`define NUM_SRC    22
`define SRC_W      5
`define NUM_SLOT   48
`define SLOT_W     6
`define REG_W      16
`define PRIO_W     6
`define LEVEL_W    3
`define NUM_LEVEL  6
`define MODE_W     8
`define VEC_W      16
`define CPU_NUM_W  5
`define ADDR_W     8
`define DATA_W     32
`define STRB_W     4

// ==========================================
// pending bit groups and cpu numbering
`define GRP0_LSB       0
`define GRP1_LSB       16
`define GRP2_LSB       32
`define LEVEL_FIRST    5'h01
`define LEVEL_LAST     5'h06
`define SW_FIRST       5'h14
`define SW_LAST        5'h1f
`define VEC_ADDR_SHIFT 1
`define PHANTOM_VEC    16'h0000
`define MODE_RESET     8'h00

// ==========================================
// register offsets and bus answers
`define OFF_REQ0    8'h00
`define OFF_REQ1    8'h04
`define OFF_REQ2    8'h08
`define OFF_ACK0    8'h0c
`define OFF_ACK1    8'h10
`define OFF_ACK2    8'h14
`define OFF_CTRL    8'h18
`define OFF_VECTOR  8'h1c
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

// ==========================================
// source table: dual, mode bit, low level/prio/bit, high level/prio/bit, code
`define SRC_TB_PER  {1'h0,3'h0,3'h3,6'h1c,6'h10,3'h3,6'h1c,6'h10,16'h002b}
`define SRC_TB_CMP  {1'h0,3'h0,3'h3,6'h1d,6'h11,3'h3,6'h1d,6'h11,16'h002c}
`define SRC_TB_UND  {1'h0,3'h0,3'h3,6'h1e,6'h12,3'h3,6'h1e,6'h12,16'h002d}
`define SRC_TB_OVF  {1'h0,3'h0,3'h3,6'h1f,6'h13,3'h3,6'h1f,6'h13,16'h002e}
`define SRC_TD_PER  {1'h0,3'h0,3'h3,6'h20,6'h28,3'h3,6'h20,6'h28,16'h0039}
`define SRC_TD_CMP  {1'h0,3'h0,3'h3,6'h21,6'h29,3'h3,6'h21,6'h29,16'h003a}
`define SRC_TD_UND  {1'h0,3'h0,3'h3,6'h22,6'h2a,3'h3,6'h22,6'h2a,16'h003b}
`define SRC_TD_OVF  {1'h0,3'h0,3'h3,6'h23,6'h2b,3'h3,6'h23,6'h2b,16'h003c}
`define SRC_CAP_A   {1'h0,3'h0,3'h4,6'h24,6'h14,3'h4,6'h24,6'h14,16'h0033}
`define SRC_CAP_B   {1'h0,3'h0,3'h4,6'h25,6'h15,3'h4,6'h25,6'h15,16'h0034}
`define SRC_CAP_C   {1'h0,3'h0,3'h4,6'h26,6'h16,3'h4,6'h26,6'h16,16'h0035}
`define SRC_CAP_D   {1'h0,3'h0,3'h4,6'h27,6'h2c,3'h4,6'h27,6'h2c,16'h0036}
`define SRC_CAP_E   {1'h0,3'h0,3'h4,6'h28,6'h2d,3'h4,6'h28,6'h2d,16'h0037}
`define SRC_CAP_F   {1'h0,3'h0,3'h4,6'h29,6'h2e,3'h4,6'h29,6'h2e,16'h0038}
`define SRC_SPI     {1'h1,3'h0,3'h5,6'h2a,6'h17,3'h1,6'h09,6'h04,16'h0005}
`define SRC_RX      {1'h1,3'h1,3'h5,6'h2b,6'h18,3'h1,6'h0a,6'h05,16'h0006}
`define SRC_TX      {1'h1,3'h2,3'h5,6'h2c,6'h19,3'h1,6'h0b,6'h06,16'h0007}
`define SRC_CANMB   {1'h1,3'h3,3'h5,6'h2d,6'h1a,3'h1,6'h0c,6'h07,16'h0040}
`define SRC_CANER   {1'h1,3'h4,3'h5,6'h2e,6'h1b,3'h1,6'h0d,6'h08,16'h0041}
`define SRC_ADC     {1'h1,3'h5,3'h6,6'h2f,6'h1c,3'h1,6'h06,6'h01,16'h0004}
`define SRC_EXT_A   {1'h1,3'h6,3'h6,6'h30,6'h1d,3'h1,6'h07,6'h02,16'h0001}
`define SRC_EXT_B   {1'h1,3'h7,3'h6,6'h31,6'h1e,3'h1,6'h08,6'h03,16'h0011}

`endif

// >>> core/expander_pkg.sv
// types of the peripheral interrupt expander
`default_nettype none
`include "expander_regs.svh"

package expander_pkg;

	// ==========================================
	// scalar types
	typedef logic [`SRC_W-1:0]   src_idx_t;
	typedef logic [`PRIO_W-1:0]  prio_t;
	typedef logic [`SLOT_W-1:0]  slot_t;
	typedef logic [`LEVEL_W-1:0] level_t;
	typedef logic [`VEC_W-1:0]   vec_t;

	// ==========================================
	// one entry of the source table
	typedef struct packed {
		logic   dual;
		logic [2:0] mode_idx;
		level_t lo_level;
		prio_t  lo_prio;
		slot_t  lo_bit;
		level_t hi_level;
		prio_t  hi_prio;
		slot_t  hi_bit;
		vec_t   vec;
	} src_s;

	// peripheral request lines from same-clock logic, lsb first at bottom
	typedef struct packed {
		logic converter_done_irq, can_fault_irq, can_mailbox_irq;
		logic serial_transmit_irq, serial_receive_irq, serial_periph_irq;
		logic capture_f_irq, capture_e_irq, capture_d_irq;
		logic capture_c_irq, capture_b_irq, capture_a_irq;
		logic timer_d_overflow_irq, timer_d_underflow_irq;
		logic timer_d_compare_irq, timer_d_period_irq;
		logic timer_b_overflow_irq, timer_b_underflow_irq;
		logic timer_b_compare_irq, timer_b_period_irq;
	} periph_irq_s;

	// cpu level request lines
	typedef struct packed {
		logic cpu_level_six, cpu_level_five, cpu_level_four;
		logic cpu_level_three, cpu_level_two, cpu_level_one;
	} cpu_levels_s;

	// cpu acknowledge of one interrupt number
	typedef struct packed {
		logic                  valid;
		logic [`CPU_NUM_W-1:0] number;
	} cpu_ack_s;

	// vector answer to an acknowledge
	typedef struct packed {
		logic valid;
		vec_t code;
		vec_t addr;
	} vector_reply_s;

endpackage
`default_nettype wire

// >>> core/level_select.sv
// picks the pending source with the smallest priority number on one level
`timescale 1ns/1ps
`default_nettype none
`include "expander_regs.svh"

module level_select (
	// candidates of one cpu level
	input  wire logic [`NUM_SRC-1:0]              cand,
	input  wire logic [`NUM_SRC-1:0][`PRIO_W-1:0] prio,
	// winner
	output logic                                  hit,
	output var expander_pkg::src_idx_t            winner
);
	import expander_pkg::*;

	prio_t best;

	// linear search for the lowest priority number
	always_comb begin
		hit = 1'b0;
		winner = '0;
		best = '1;
		for (int i = 0; i < `NUM_SRC; i++) begin
			if (cand[i] && (!hit || prio[i] < best)) begin
				hit = 1'b1;
				winner = src_idx_t'(i);
				best = prio[i];
			end
		end
	end

endmodule // level_select
`default_nettype wire

// >>> core/peripheral_interrupt_expander.sv
// peripheral interrupt expander with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "expander_regs.svh"

module peripheral_interrupt_expander #(
	parameter logic [`NUM_SRC-1:0] SOURCE_PRESENT = '1
) (
	// clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// axi4-lite write address
	input  wire logic [`ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	// axi4-lite write data
	input  wire logic [`DATA_W-1:0]     s_axi_wdata,
	input  wire logic [`STRB_W-1:0]     s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// axi4-lite read
	input  wire logic [`ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [`DATA_W-1:0]          s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// peripheral side
	input  wire expander_pkg::periph_irq_s periph_irq,
	input  wire logic                   ext_pin_irq_a,
	input  wire logic                   ext_pin_irq_b,
	output logic [`NUM_SRC-1:0]         periph_ack_pulse,
	// cpu side
	output var expander_pkg::cpu_levels_s   cpu_levels,
	input  wire expander_pkg::cpu_ack_s     cpu_ack,
	output var expander_pkg::vector_reply_s vector_reply
);
	import expander_pkg::*;

	// ==========================================
	// source table, index order matches the request inputs
	localparam src_s SRC_TABLE [`NUM_SRC] = '{
		`SRC_TB_PER, `SRC_TB_CMP, `SRC_TB_UND, `SRC_TB_OVF,
		`SRC_TD_PER, `SRC_TD_CMP, `SRC_TD_UND, `SRC_TD_OVF,
		`SRC_CAP_A, `SRC_CAP_B, `SRC_CAP_C,
		`SRC_CAP_D, `SRC_CAP_E, `SRC_CAP_F,
		`SRC_SPI, `SRC_RX, `SRC_TX,
		`SRC_CANMB, `SRC_CANER,
		`SRC_ADC, `SRC_EXT_A, `SRC_EXT_B
	};

	// ==========================================
	// state and nets
	logic [`NUM_SLOT-1:0]           peripheral_request_regs;
	logic [`NUM_SLOT-1:0]           peripheral_ack_regs;
	logic [`MODE_W-1:0]             high_mode;
	logic [1:0]                     ext_meta;
	logic [1:0]                     ext_sync;
	logic [1:0]                     ext_prev;
	logic [`NUM_SRC-1:0]            raw_event;
	logic [`NUM_SRC-1:0]            src_high;
	logic [`NUM_SRC-1:0]            src_pend;
	slot_t                          src_bit [`NUM_SRC];
	level_t                         src_level [`NUM_SRC];
	logic [`NUM_SRC-1:0][`PRIO_W-1:0] src_prio;
	logic [`NUM_LEVEL-1:0][`NUM_SRC-1:0] level_cand;
	logic [`NUM_LEVEL-1:0]          level_hit;
	src_idx_t                       level_win [`NUM_LEVEL];
	logic [`NUM_SLOT-1:0]           set_vec;
	logic [`NUM_SLOT-1:0]           ack_clr;
	logic [`NUM_SLOT-1:0]           sw_clr_req;
	logic [`NUM_SLOT-1:0]           sw_clr_ack;
	logic                           ack_periph;
	level_t                         ack_lvl;
	src_idx_t                       win;
	logic                           win_hit;

	// ==========================================
	// external pins: two-stage synchroniser, then rising edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_meta <= 2'h0;
			ext_sync <= 2'h0;
			ext_prev <= 2'h0;
		end else begin
			ext_meta <= {ext_pin_irq_b, ext_pin_irq_a};
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// missing peripherals never raise a request
	assign raw_event = {ext_sync & ~ext_prev, periph_irq} & SOURCE_PRESENT;

	// ==========================================
	// per source: mode, pending bit, level and priority
	for (genvar s = 0; s < `NUM_SRC; s++) begin : g_src
		assign src_high[s] = SRC_TABLE[s].dual
			&& high_mode[SRC_TABLE[s].mode_idx];
		assign src_bit[s] = src_high[s] ? SRC_TABLE[s].hi_bit
			: SRC_TABLE[s].lo_bit;
		assign src_level[s] = src_high[s] ? SRC_TABLE[s].hi_level
			: SRC_TABLE[s].lo_level;
		assign src_prio[s] = src_high[s] ? SRC_TABLE[s].hi_prio
			: SRC_TABLE[s].lo_prio;
		assign src_pend[s] = peripheral_request_regs[src_bit[s]];
		for (genvar l = 0; l < `NUM_LEVEL; l++) begin : g_lvl
			assign level_cand[l][s] = src_pend[s]
				&& (src_level[s] == level_t'(l + 1));
		end
	end

	// ==========================================
	// one priority search per cpu level
	for (genvar l = 0; l < `NUM_LEVEL; l++) begin : g_sel
		level_select u_sel (
			.cand   (level_cand[l]),
			.prio   (src_prio),
			.hit    (level_hit[l]),
			.winner (level_win[l])
		);
	end

	// ==========================================
	// acknowledge decode, numbers outside levels one to six get no source
	assign ack_periph = cpu_ack.valid
		&& (cpu_ack.number >= `LEVEL_FIRST)
		&& (cpu_ack.number <= `LEVEL_LAST);
	assign ack_lvl = level_t'(cpu_ack.number - `LEVEL_FIRST);
	assign win = level_win[ack_lvl];
	assign win_hit = ack_periph && level_hit[ack_lvl];

	// request set from events, clear from the acknowledged winner
	always_comb begin
		set_vec = '0;
		ack_clr = '0;
		for (int s = 0; s < `NUM_SRC; s++) begin
			if (raw_event[s]) begin
				set_vec[src_bit[s]] = 1'b1;
			end
		end
		if (win_hit) begin
			ack_clr[src_bit[win]] = 1'b1;
		end
	end

	// ==========================================
	// pending requests, a new event beats any clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			peripheral_request_regs <= '0;
		end else begin
			peripheral_request_regs <= set_vec
				| (peripheral_request_regs & ~ack_clr & ~sw_clr_req);
		end
	end

	// acknowledge bits, set wins over a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			peripheral_ack_regs <= '0;
		end else begin
			peripheral_ack_regs <= ack_clr
				| (peripheral_ack_regs & ~sw_clr_ack);
		end
	end

	// one-cycle acknowledge strobe to the winning peripheral
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_ack_pulse <= '0;
		end else begin
			periph_ack_pulse <= '0;
			if (win_hit) begin
				periph_ack_pulse[win] <= 1'b1;
			end
		end
	end

	// level lines to the cpu
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_levels <= '0;
		end else begin
			cpu_levels <= cpu_levels_s'(level_hit);
		end
	end

	// vector answer, phantom code when nothing is pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vector_reply <= '0;
		end else begin
			vector_reply.valid <= cpu_ack.valid;
			if (cpu_ack.valid) begin
				vector_reply.code <= win_hit ? SRC_TABLE[win].vec
					: `PHANTOM_VEC;
				vector_reply.addr <= vec_t'(cpu_ack.number)
					<< `VEC_ADDR_SHIFT;
			end
		end
	end

	// ==========================================
	// axi4-lite write channel
	logic                   aw_held;
	logic                   w_held;
	logic [`ADDR_W-1:0]     aw_addr_q;
	logic [`DATA_W-1:0]     w_data_q;
	logic [`STRB_W-1:0]     w_strb_q;
	logic                   aw_now;
	logic                   w_now;
	logic [`ADDR_W-1:0]     wr_addr;
	logic [`DATA_W-1:0]     wr_data;
	logic [`STRB_W-1:0]     wr_strb;
	logic                   do_write;
	logic                   wr_ok;
	logic [`REG_W-1:0]      wr_mask;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign aw_now = aw_held || (s_axi_awvalid && s_axi_awready);
	assign w_now = w_held || (s_axi_wvalid && s_axi_wready);
	assign do_write = aw_now && w_now;
	assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
	assign wr_data = w_held ? w_data_q : s_axi_wdata;
	assign wr_strb = w_held ? w_strb_q : s_axi_wstrb;
	assign wr_mask = wr_data[`REG_W-1:0]
		& {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// hold whichever half arrives first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
		end
	end

	// write decode: clear-by-one on request and ack groups
	always_comb begin
		sw_clr_req = '0;
		sw_clr_ack = '0;
		wr_ok = 1'b1;
		case ({wr_addr[`ADDR_W-1:2], 2'h0})
			`OFF_REQ0: sw_clr_req[`GRP0_LSB +: `REG_W] = wr_mask;
			`OFF_REQ1: sw_clr_req[`GRP1_LSB +: `REG_W] = wr_mask;
			`OFF_REQ2: sw_clr_req[`GRP2_LSB +: `REG_W] = wr_mask;
			`OFF_ACK0: sw_clr_ack[`GRP0_LSB +: `REG_W] = wr_mask;
			`OFF_ACK1: sw_clr_ack[`GRP1_LSB +: `REG_W] = wr_mask;
			`OFF_ACK2: sw_clr_ack[`GRP2_LSB +: `REG_W] = wr_mask;
			`OFF_CTRL, `OFF_VECTOR: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
		if (!do_write) begin
			sw_clr_req = '0;
			sw_clr_ack = '0;
		end
	end

	// priority mode select, one bit per dual-mode source
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_mode <= `MODE_RESET;
		end else if (do_write && wr_strb[0]
			&& ({wr_addr[`ADDR_W-1:2], 2'h0} == `OFF_CTRL)) begin
			high_mode <= wr_data[`MODE_W-1:0];
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================
	// axi4-lite read channel
	logic [`DATA_W-1:0] rd_data;
	logic               rd_ok;

	assign s_axi_arready = !s_axi_rvalid;

	// read mux, unused upper bits read as zero
	always_comb begin
		rd_data = '0;
		rd_ok = 1'b1;
		case ({s_axi_araddr[`ADDR_W-1:2], 2'h0})
			`OFF_REQ0: rd_data[`REG_W-1:0] = peripheral_request_regs[`GRP0_LSB +: `REG_W];
			`OFF_REQ1: rd_data[`REG_W-1:0] = peripheral_request_regs[`GRP1_LSB +: `REG_W];
			`OFF_REQ2: rd_data[`REG_W-1:0] = peripheral_request_regs[`GRP2_LSB +: `REG_W];
			`OFF_ACK0: rd_data[`REG_W-1:0] = peripheral_ack_regs[`GRP0_LSB +: `REG_W];
			`OFF_ACK1: rd_data[`REG_W-1:0] = peripheral_ack_regs[`GRP1_LSB +: `REG_W];
			`OFF_ACK2: rd_data[`REG_W-1:0] = peripheral_ack_regs[`GRP2_LSB +: `REG_W];
			`OFF_CTRL: rd_data[`MODE_W-1:0] = high_mode;
			`OFF_VECTOR: rd_data[`VEC_W-1:0] = vector_reply.code;
			default: rd_ok = 1'b0;
		endcase
	end

	// read data register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // peripheral_interrupt_expander
`default_nettype wire

// >>> bench/expander_properties.sv
// concurrent checks on the ports of the peripheral interrupt expander
`timescale 1ns/1ps
`default_nettype none
`include "expander_regs.svh"

module expander_properties (
	// clock and reset
	input wire logic                        aclk,
	input wire logic                        aresetn,
	// peripheral side
	input wire expander_pkg::periph_irq_s   periph_irq,
	input wire logic [`NUM_SRC-1:0]         periph_ack_pulse,
	// cpu side
	input wire expander_pkg::cpu_levels_s   cpu_levels,
	input wire expander_pkg::cpu_ack_s      cpu_ack,
	input wire expander_pkg::vector_reply_s vector_reply
);
	import expander_pkg::*;

	// ==========================================
	// acknowledge steps
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ack;
		cpu_ack.valid;
	endsequence
	sequence s_reply;
		##1 vector_reply.valid;
	endsequence

	// ==========================================
	// vector answer
	chk_reply_follows: assert property (s_ack |-> s_reply)
		else $error("no vector reply one cycle after acknowledge");
	chk_reply_pulse: assert property (!cpu_ack.valid |=> !vector_reply.valid)
		else $error("vector reply without acknowledge");
	chk_reply_addr: assert property (cpu_ack.valid && cpu_ack.number inside {[1:6]}
		|=> vector_reply.addr == {10'h000, $past(cpu_ack.number), 1'b0})
		else $error("vector address does not match level");
	chk_soft_phantom: assert property (cpu_ack.valid && cpu_ack.number >= 5'h14
		|=> vector_reply.code == 16'h0000 && periph_ack_pulse == '0)
		else $error("software interrupt got a peripheral code");
	chk_pulse_onehot: assert property ($onehot0(periph_ack_pulse))
		else $error("more than one source acknowledged");
	chk_pulse_reply: assert property (|periph_ack_pulse
		|-> vector_reply.valid && vector_reply.code != 16'h0000)
		else $error("acknowledge pulse without a real vector");

	// ==========================================
	// request to level
	chk_timer_b_level: assert property (periph_irq.timer_b_period_irq
		|-> ##2 cpu_levels.cpu_level_three)
		else $error("timer b period did not raise level three");
	chk_timer_d_level: assert property (periph_irq.timer_d_overflow_irq
		|-> ##2 cpu_levels.cpu_level_three)
		else $error("timer d overflow did not raise level three");
	chk_adc_level: assert property (periph_irq.converter_done_irq
		|-> ##2 (cpu_levels.cpu_level_six || cpu_levels.cpu_level_one))
		else $error("converter done raised no level");
	chk_serial_level: assert property (periph_irq.serial_periph_irq
		|-> ##2 (cpu_levels.cpu_level_five || cpu_levels.cpu_level_one))
		else $error("serial peripheral raised no level");
endmodule // expander_properties
`default_nettype wire

// >>> bench/cpu_core_model.sv
// acknowledging cpu core standing at the far side of the expander
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// commands from the bench
	input wire logic              go,
	input wire logic [4:0]        num,
	input wire logic [3:0]        lag,
	// acknowledge to the expander
	output var expander_pkg::cpu_ack_s cpu_ack
);
	import expander_pkg::*;
	logic [3:0] cnt;
	logic       armed;

	// waits lag cycles, then a one-cycle acknowledge of the chosen number
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_ack <= '0;
			armed <= 1'b0;
			cnt <= 4'h0;
		end else begin
			cpu_ack.valid <= 1'b0;
			if (go) begin
				armed <= 1'b1;
				cnt <= lag;
				cpu_ack.number <= num;
			end else if (armed && cnt == 4'h0) begin
				cpu_ack.valid <= 1'b1;
				armed <= 1'b0;
			end else if (armed) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule // cpu_core_model
`default_nettype wire

// >>> bench/peripheral_interrupt_expander_tb_top.sv
// self-checking bench of the peripheral interrupt expander
`timescale 1ns/1ps
`default_nettype none

module peripheral_interrupt_expander_tb_top;
	import expander_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	periph_irq_s periph_irq = '0;
	logic ext_pin_irq_a = 1'b0, ext_pin_irq_b = 1'b0, go = 1'b0;
	logic [4:0] ack_num = 5'h00;
	logic [3:0] ack_lag = 4'h0;
	logic [21:0] periph_ack_pulse, pulse_seen;
	cpu_levels_s cpu_levels;
	cpu_ack_s cpu_ack;
	vector_reply_s vector_reply;
	int fails = 0, checks_done = 0;
	logic [15:0] tcode [8] = '{16'h002b, 16'h002c, 16'h002d, 16'h002e,
		16'h0039, 16'h003a, 16'h003b, 16'h003c};
	logic [15:0] lcode [8] = '{16'h0005, 16'h0006, 16'h0007, 16'h0040,
		16'h0041, 16'h0004, 16'h0001, 16'h0011};

	// ==========================================
	// clock, design and partner
	always #5 aclk = ~aclk;
	peripheral_interrupt_expander #(.SOURCE_PRESENT(22'h3fdfff)) DUT (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .periph_irq(periph_irq), .ext_pin_irq_a(ext_pin_irq_a),
		.ext_pin_irq_b(ext_pin_irq_b), .periph_ack_pulse(periph_ack_pulse),
		.cpu_levels(cpu_levels), .cpu_ack(cpu_ack), .vector_reply(vector_reply));
	cpu_core_model u_cpu (.aclk(aclk), .aresetn(aresetn), .go(go), .num(ack_num),
		.lag(ack_lag), .cpu_ack(cpu_ack));

	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = (s_axi_bvalid === 1'b1);
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		v = 1'b0;
		while (!v) begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			v = (s_axi_rvalid === 1'b1);
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		check(d, exp);
	endtask
	task automatic pulse(input logic [19:0] m);
		@(posedge aclk);
		periph_irq <= periph_irq_s'(m);
		@(posedge aclk);
		periph_irq <= '0;
		repeat (2) @(posedge aclk);
	endtask
	// the cpu model acknowledges after lag cycles; code and address are judged
	task automatic ack(input logic [4:0] n, input logic [3:0] l, input logic [15:0] c,
		input logic [15:0] va);
		@(posedge aclk);
		go <= 1'b1;
		ack_num <= n;
		ack_lag <= l;
		@(posedge aclk);
		go <= 1'b0;
		do @(negedge aclk); while (vector_reply.valid !== 1'b1);
		check(32'(vector_reply.code), 32'(c));
		check(32'(vector_reply.addr), 32'(va));
		pulse_seen = periph_ack_pulse;
	endtask

	// ==========================================
	// scenarios
	task automatic scn_timers();
		logic [1:0] r;
		pulse(20'h000ff);
		rd_check(8'h04, 32'h0000000f);
		rd_check(8'h08, 32'h00000f00);
		@(negedge aclk);
		check(32'(cpu_levels), 32'h00000004);
		for (int i = 0; i < 8; i++) begin
			ack(5'h03, 4'(i), tcode[i], 16'h0006);
			check(32'(pulse_seen), 32'(1 << i));
		end
		rd_check(8'h10, 32'h0000000f);
		rd_check(8'h14, 32'h00000f00);
		rd_check(8'h04, 32'h00000000);
		@(negedge aclk);
		check(32'(cpu_levels), 32'h00000000);
		axi_wr(8'h10, 32'h0000ffff, r);
		axi_wr(8'h14, 32'h0000ffff, r);
	endtask
	task automatic scn_low_mode();
		@(posedge aclk);
		ext_pin_irq_a <= 1'b1;
		ext_pin_irq_b <= 1'b1;
		pulse(20'hfc000);
		repeat (4) @(posedge aclk);
		rd_check(8'h04, 32'h00007f80);
		for (int i = 0; i < 8; i++) begin
			if (i < 5) ack(5'h05, 4'(i), lcode[i], 16'h000a);
			else ack(5'h06, 4'h0, lcode[i], 16'h000c);
		end
		@(posedge aclk);
		ext_pin_irq_a <= 1'b0;
		ext_pin_irq_b <= 1'b0;
	endtask
	task automatic scn_high_mode();
		logic [1:0] r;
		axi_wr(8'h18, 32'h00000021, r);
		pulse(20'h84000);
		rd_check(8'h00, 32'h00000012);
		ack(5'h01, 4'h2, 16'h0004, 16'h0002);
		ack(5'h01, 4'h0, 16'h0005, 16'h0002);
		rd_check(8'h1c, 32'h00000005);
		axi_wr(8'h18, 32'h00000000, r);
	endtask
	task automatic scn_phantom();
		ack(5'h14, 4'h0, 16'h0000, 16'h0028);
		ack(5'h1f, 4'h1, 16'h0000, 16'h003e);
		ack(5'h03, 4'h0, 16'h0000, 16'h0006);
		check(32'(pulse_seen), 32'h0);
	endtask
	task automatic scn_absent_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		pulse(20'h02100);
		rd_check(8'h08, 32'h00000000);
		rd_check(8'h04, 32'h00000010);
		axi_rd(8'h40, d, r);
		check(32'(r), 32'h2);
		check(d, 32'h0);
		axi_wr(8'h40, 32'h0000ffff, r);
		check(32'(r), 32'h2);
	endtask

	// ==========================================
	// closing, watchdog and main sequence
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd_check(8'h18, 32'h00000000);
		scn_timers();
		scn_low_mode();
		scn_high_mode();
		scn_phantom();
		scn_absent_unmapped();
		final_report();
	end
endmodule // peripheral_interrupt_expander_tb_top

bind peripheral_interrupt_expander expander_properties u_chk (.aclk(aclk),
	.aresetn(aresetn), .periph_irq(periph_irq), .periph_ack_pulse(periph_ack_pulse),
	.cpu_levels(cpu_levels), .cpu_ack(cpu_ack), .vector_reply(vector_reply));
`default_nettype wire
